/* common/lec_gate_if.sv */
// carrier between the register block and the transmit gate
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface lec_gate_if;
  logic [1:0]  thresh_sel;
  logic        retries_zero;
  logic [11:0] fifo_bytes;
  logic        eop_in_fifo;
  logic        underrun;
  logic        pkt_done;
  logic        send_permit;
  logic        store_fwd;
  logic        retry_mode;

  modport ctrl (
    output thresh_sel, retries_zero, fifo_bytes, eop_in_fifo,
    output underrun, pkt_done,
    input  send_permit, store_fwd, retry_mode
  );
  modport gate (
    input  thresh_sel, retries_zero, fifo_bytes, eop_in_fifo,
    input  underrun, pkt_done,
    output send_permit, store_fwd, retry_mode
  );
endinterface

/* common/lec_pkg.sv */
// constants for the link tuning control register block
// assumes an apb slave on pclk with 8-bit byte addressing of the window
package lec_pkg;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam int          LEC_AW        = 8;
  localparam logic [7:0]  LEC_CTRL_OFF  = 8'hf4;
  localparam logic [7:0]  LEC_STAT_OFF  = 8'hf0;
  localparam logic [31:0] LEC_CTRL_RST  = 32'h0000_1000;

  // --------------------------------------------------------------
  // control field positions
  // --------------------------------------------------------------
  localparam int LEC_B_PIPE_DIS = 15;
  localparam int LEC_B_THR_HI   = 13;
  localparam int LEC_B_THR_LO   = 12;
  localparam int LEC_B_MPEG     = 10;
  localparam int LEC_B_DV       = 8;
  localparam int LEC_B_PRIO     = 7;
  localparam int LEC_B_PHYPROG  = 6;
  localparam int LEC_B_ACCEL    = 1;

  // --------------------------------------------------------------
  // status field positions
  // --------------------------------------------------------------
  localparam int LEC_S_THR_LO   = 0;
  localparam int LEC_S_THR_HI   = 1;
  localparam int LEC_S_SFWD     = 2;
  localparam int LEC_S_RETRY    = 3;
  localparam int LEC_S_PERMIT   = 4;

  // --------------------------------------------------------------
  // threshold codes and byte counts
  // --------------------------------------------------------------
  localparam logic [1:0] LEC_THR_2K   = 2'h0;
  localparam logic [1:0] LEC_THR_1K7  = 2'h1;
  localparam logic [1:0] LEC_THR_1K   = 2'h2;
  localparam logic [1:0] LEC_THR_512  = 2'h3;
  localparam int         LEC_FB_W     = 12;
  localparam logic [11:0] LEC_BYTES_1K7 = 12'h6cc;
  localparam logic [11:0] LEC_BYTES_1K  = 12'h400;
  localparam logic [11:0] LEC_BYTES_512 = 12'h200;

  // --------------------------------------------------------------
  // cip stream format codes
  // --------------------------------------------------------------
  localparam logic [5:0] LEC_FMT_MPEG = 6'h20;
  localparam logic [5:0] LEC_FMT_DV   = 6'h00;

endpackage

/* hw/lec_link_tuning.sv */
// link tuning control register with its apb slave and output controls
// assumes an apb master on pclk and link-side inputs on the same clock
//
// What this block does
// R1 - 2k threshold: send an async packet only once its end is in fifo.
// R2 - zero async retry count forces store-and-forward for any threshold.
// R3 - mpeg stamp enable (bit 10) stamps cip streams with format 20h.
// R4 - dv stamp enable (bit 8) stamps cip streams with format 00h.
// R5 - priority enable (bit 7) makes the link use priority arbitration.
// R6 - acceleration enable (bit 1) tells the phy acceleration is supported.
// R7 - bit 6 has no function even when loaded from the config memory.
// R8 - bits 11, 9, 5-2 and 0 always read zero.
// R9 - threshold field 13-12: 2k, 1.7k (default), 1k, 512 bytes.
// R10 - after an underrun the retry uses 2k store-and-forward.
// R11 - pipeline disable (bit 15) stops out-of-order async pipelining.
// R12 - reset value 0000_1000h; bits 31-16 read zero.
// R13 - writes to reserved positions have no effect.
`timescale 1ns/1ps
module lec_link_tuning (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [lec_pkg::LEC_AW-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // serial configuration memory load
  input  wire logic                  cfg_load,
  input  wire logic [15:0]           cfg_enh,
  // async transmit fifo side
  input  wire logic                  at_retries_zero,
  input  wire logic [lec_pkg::LEC_FB_W-1:0] at_fifo_bytes,
  input  wire logic                  at_eop_in_fifo,
  input  wire logic                  at_underrun,
  input  wire logic                  at_pkt_done,
  output logic                       at_send_permit,
  output logic                       at_store_fwd,
  output logic                       async_pipeline_disable,
  // isochronous transmit stream
  input  wire logic                  iso_hdr_valid,
  input  wire logic [5:0]            iso_fmt,
  output logic                       stamp_apply,
  // arbitration and phy notice
  output logic                       prio_arb_enable,
  output logic                       phy_accel_notify
);
  import lec_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic        pipe_dis;
    logic [1:0]  thresh;
    logic        mpeg;
    logic        dv;
    logic        prio;
    logic        accel;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        stamp;
  } lec_top_s;

  lec_top_s st_r;
  lec_top_s st_nxt;

  lec_gate_if gif ();

  logic        setup_ph;
  logic        acc_wr;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [31:0] ctrl_img;
  logic [31:0] stat_img;

  // reset value taken apart once, so only the package holds it
  localparam lec_top_s LEC_RST_S = '{
    pipe_dis: LEC_CTRL_RST[LEC_B_PIPE_DIS],
    thresh:   LEC_CTRL_RST[LEC_B_THR_HI:LEC_B_THR_LO],
    mpeg:     LEC_CTRL_RST[LEC_B_MPEG],
    dv:       LEC_CTRL_RST[LEC_B_DV],
    prio:     LEC_CTRL_RST[LEC_B_PRIO],
    accel:    LEC_CTRL_RST[LEC_B_ACCEL],
    pready:   1'b0,
    pslverr:  1'b0,
    prdata:   32'h0000_0000,
    stamp:    1'b0
  };

  // --------------------------------------------------------------
  // transmit gate
  // --------------------------------------------------------------
  assign gif.thresh_sel   = st_r.thresh;
  assign gif.retries_zero = at_retries_zero;
  assign gif.fifo_bytes   = at_fifo_bytes;
  assign gif.eop_in_fifo  = at_eop_in_fifo;
  assign gif.underrun     = at_underrun;
  assign gif.pkt_done     = at_pkt_done;

  lec_tx_gate u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .g       (gif.gate)
  );

  // --------------------------------------------------------------
  // read images
  // --------------------------------------------------------------
  always_comb begin
    // only named fields land; every other bit stays zero
    ctrl_img                              = 32'h0000_0000;  // see R8
    ctrl_img[LEC_B_PIPE_DIS]              = st_r.pipe_dis;
    ctrl_img[LEC_B_THR_HI:LEC_B_THR_LO]   = st_r.thresh;
    ctrl_img[LEC_B_MPEG]                  = st_r.mpeg;
    ctrl_img[LEC_B_DV]                    = st_r.dv;
    ctrl_img[LEC_B_PRIO]                  = st_r.prio;
    ctrl_img[LEC_B_ACCEL]                 = st_r.accel;
    stat_img                              = 32'h0000_0000;
    stat_img[LEC_S_THR_HI:LEC_S_THR_LO]   = st_r.thresh;
    stat_img[LEC_S_SFWD]                  = gif.store_fwd;
    stat_img[LEC_S_RETRY]                 = gif.retry_mode;
    stat_img[LEC_S_PERMIT]                = gif.send_permit;
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    setup_ph = psel & ~penable;
    acc_wr   = psel & penable & st_r.pready & pwrite;
    hit_ctrl = (paddr == LEC_CTRL_OFF);
    hit_stat = (paddr == LEC_STAT_OFF);

    // one pready pulse per transfer, raised out of the setup cycle
    st_nxt.pready  = setup_ph;
    st_nxt.pslverr = setup_ph & ~hit_ctrl & ~(hit_stat & ~pwrite);
    st_nxt.prdata  = 32'h0000_0000;
    if (setup_ph && !pwrite) begin
      if (hit_ctrl) begin
        st_nxt.prdata = ctrl_img;  // see R12
      end else if (hit_stat) begin
        st_nxt.prdata = stat_img;
      end
    end

    // config memory load first, so a bus write of the same cycle wins
    if (cfg_load) begin
      st_nxt.pipe_dis = cfg_enh[LEC_B_PIPE_DIS];
      st_nxt.thresh   = cfg_enh[LEC_B_THR_HI:LEC_B_THR_LO];
      st_nxt.mpeg     = cfg_enh[LEC_B_MPEG];
      st_nxt.dv       = cfg_enh[LEC_B_DV];
      st_nxt.prio     = cfg_enh[LEC_B_PRIO];
      st_nxt.accel    = cfg_enh[LEC_B_ACCEL];
      // bit 6 is dropped here: nothing stores it  see R7
    end

    // only writable fields take pwdata  see R13
    if (acc_wr && hit_ctrl) begin
      st_nxt.pipe_dis = pwdata[LEC_B_PIPE_DIS];
      st_nxt.thresh   = pwdata[LEC_B_THR_HI:LEC_B_THR_LO];  // see R9
      st_nxt.mpeg     = pwdata[LEC_B_MPEG];
      st_nxt.dv       = pwdata[LEC_B_DV];
      st_nxt.prio     = pwdata[LEC_B_PRIO];
      st_nxt.accel    = pwdata[LEC_B_ACCEL];
    end

    // stamp decision per stream header
    st_nxt.stamp = iso_hdr_valid &
                   ((st_r.mpeg & (iso_fmt == LEC_FMT_MPEG)) |  // see R3
                    (st_r.dv   & (iso_fmt == LEC_FMT_DV)));    // see R4
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= LEC_RST_S;  // see R12
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // --------------------------------------------------------------
  assign pready                 = st_r.pready;
  assign prdata                 = st_r.prdata;
  assign pslverr                = st_r.pslverr;
  assign at_send_permit         = gif.send_permit;  // see R1
  assign at_store_fwd           = gif.store_fwd;    // see R2
  assign async_pipeline_disable = st_r.pipe_dis;    // see R11
  assign stamp_apply            = st_r.stamp;
  assign prio_arb_enable        = st_r.prio;        // see R5
  assign phy_accel_notify       = st_r.accel;       // see R6

endmodule

/* hw/lec_tx_gate.sv */
// asynchronous transmit start gate: threshold versus store-and-forward
// assumes fifo status and packet events come from logic on pclk
`timescale 1ns/1ps
module lec_tx_gate (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // towards the register block
  lec_gate_if.gate g
);
  import lec_pkg::*;

  typedef struct packed {
    logic retry;
    logic sfwd;
    logic permit;
  } lec_gate_s;

  lec_gate_s st_r;
  lec_gate_s st_nxt;
  logic [11:0] thr_bytes;
  logic        sfwd_now;
  logic        retry_now;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (g.thresh_sel)  // see R9
      LEC_THR_1K7: thr_bytes = LEC_BYTES_1K7;
      LEC_THR_1K:  thr_bytes = LEC_BYTES_1K;
      LEC_THR_512: thr_bytes = LEC_BYTES_512;
      default:     thr_bytes = LEC_BYTES_1K7;
    endcase
    // underrun wins over the completion of the same cycle
    retry_now = g.underrun | (st_r.retry & ~g.pkt_done);  // see R10
    // store-and-forward for 2k code, zero retries, or a retry pass
    sfwd_now = (g.thresh_sel == LEC_THR_2K)  // see R1
             | g.retries_zero                // see R2
             | retry_now;                    // see R10
    st_nxt.retry  = retry_now;
    st_nxt.sfwd   = sfwd_now;
    // a whole packet in the fifo always may go
    st_nxt.permit = g.eop_in_fifo                          // see R1
                  | (~sfwd_now & (g.fifo_bytes >= thr_bytes));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign g.send_permit = st_r.permit;
  assign g.store_fwd   = st_r.sfwd;
  assign g.retry_mode  = st_r.retry;

endmodule

/* testbench/lec_fifo_model.sv */
// async transmit fifo model behind the gate inputs
// assumes the bench starts one packet at a time and waits for its end
`timescale 1ns/1ps
module lec_fifo_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bench commands
  input  wire logic        start,
  input  wire logic [11:0] pkt_len,
  // gate side
  input  wire logic        at_send_permit,
  output logic [11:0]      at_fifo_bytes,
  output logic             at_eop_in_fifo,
  output logic             at_underrun,
  output logic             at_pkt_done
);
  // host fills slowly, so a partial threshold can run the fifo dry
  localparam logic [11:0] RATE = 12'h010;
  logic [11:0] len_r;
  logic [2:0]  tx_r;
  logic        busy_r;
  logic        fin_r;
  assign at_eop_in_fifo = len_r != 12'h000 && at_fifo_bytes == len_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {at_fifo_bytes, len_r, tx_r, busy_r, fin_r} <= '0;
      {at_underrun, at_pkt_done} <= 2'b00;
    end else begin
      at_underrun <= 1'b0;
      at_pkt_done <= 1'b0;
      if (start) begin
        {at_fifo_bytes, tx_r, busy_r, fin_r} <= '0;
        len_r <= pkt_len;
      end else begin
        at_fifo_bytes <= (at_fifo_bytes + RATE < len_r) ?
                         at_fifo_bytes + RATE : len_r;
        if (busy_r) begin
          tx_r <= tx_r - 3'h1;
          if (tx_r == 3'h1) begin
            busy_r <= 1'b0;
            fin_r <= at_eop_in_fifo;
            at_pkt_done <= at_eop_in_fifo;
            // end token missing when the data ran out
            at_underrun <= !at_eop_in_fifo;
          end
        end else if (at_send_permit && !at_underrun && !fin_r
                     && len_r != 12'h000 && at_fifo_bytes != 12'h000) begin
          // empty fifo: a permit left from the last packet is stale
          busy_r <= 1'b1;
          tx_r <= 3'h4;
        end
      end
    end
  end
endmodule

/* testbench/lec_link_tuning_assertions.sv */
// checker for the link tuning register block, bound to its top module
// assumes a zero-wait apb slave and link-side inputs on pclk
`timescale 1ns/1ps
module lec_link_tuning_chk
  import lec_pkg::*;
(
  // apb side
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [LEC_AW-1:0]   paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  // link side
  input wire logic                cfg_load,
  input wire logic                at_retries_zero,
  input wire logic                at_eop_in_fifo,
  input wire logic                at_underrun,
  input wire logic                at_pkt_done,
  input wire logic                at_send_permit,
  input wire logic                at_store_fwd,
  input wire logic                iso_hdr_valid,
  input wire logic                async_pipeline_disable,
  input wire logic                stamp_apply,
  input wire logic                prio_arb_enable,
  input wire logic                phy_accel_notify,
  input wire logic [15:0]         cfg_enh,
  input wire logic [LEC_FB_W-1:0] at_fifo_bytes,
  input wire logic [5:0]          iso_fmt
);
  // ------------
  // mirror of the writable bits and of the retry pass
  // ------------
  localparam logic [15:0] WMASK = 16'hb582;
  logic [15:0] mir_r;
  logic        rty_r;
  logic [11:0] thb;
  logic        hit;
  logic        stamp_exp;
  assign thb = (mir_r[13:12] == LEC_THR_1K7) ? LEC_BYTES_1K7 :
               (mir_r[13:12] == LEC_THR_1K) ? LEC_BYTES_1K : LEC_BYTES_512;
  assign hit = at_eop_in_fifo || (at_fifo_bytes >= thb);
  assign stamp_exp = iso_hdr_valid && ((mir_r[10] && iso_fmt == LEC_FMT_MPEG)
                     || (mir_r[8] && iso_fmt == LEC_FMT_DV));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mir_r <= LEC_CTRL_RST[15:0];
      rty_r <= 1'b0;
    end else begin
      // a write in the same cycle wins over a memory load
      if (psel && penable && pready && pwrite && paddr == LEC_CTRL_OFF)
        mir_r <= pwdata[15:0] & WMASK;
      else if (cfg_load)
        mir_r <= cfg_enh & WMASK;
      rty_r <= at_underrun || (rty_r && !at_pkt_done);
    end
  end
  // ------------
  // properties
  // ------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer is not a one cycle pulse");
  a_read_value: assert property (
    pready && !pwrite && paddr == LEC_CTRL_OFF
    |-> prdata == {16'h0000, $past(mir_r)} && !pslverr)
    else $error("control read value wrong");
  a_unmapped_err: assert property (
    psel && !penable && paddr != LEC_CTRL_OFF && paddr != LEC_STAT_OFF
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_outs_follow: assert property (
    {async_pipeline_disable, prio_arb_enable, phy_accel_notify}
    == {mir_r[15], mir_r[7], mir_r[1]})
    else $error("control outputs differ from register");
  a_stamp_rule: assert property (
    1'b1 |=> stamp_apply == $past(stamp_exp))
    else $error("stamp decision wrong");
  a_sfwd_zero: assert property (at_retries_zero
    |=> at_store_fwd && at_send_permit == $past(at_eop_in_fifo))
    else $error("zero retries without store and forward");
  a_full_pkt: assert property (mir_r[13:12] == LEC_THR_2K
    |=> at_store_fwd && at_send_permit == $past(at_eop_in_fifo))
    else $error("largest threshold sent a partial packet");
  a_retry_sfwd: assert property (
    at_underrun || (rty_r && !at_pkt_done)
    |=> at_store_fwd && at_send_permit == $past(at_eop_in_fifo))
    else $error("retry pass not store and forward");
  a_thresh_level: assert property (
    !at_retries_zero && !at_underrun && !rty_r && mir_r[13:12] != LEC_THR_2K
    |=> !at_store_fwd && at_send_permit == $past(hit))
    else $error("threshold permit wrong");
endmodule

bind lec_link_tuning lec_link_tuning_chk u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .cfg_load,
  .at_retries_zero, .at_eop_in_fifo, .at_underrun, .at_pkt_done,
  .at_send_permit, .at_store_fwd, .iso_hdr_valid, .async_pipeline_disable,
  .stamp_apply, .prio_arb_enable, .phy_accel_notify, .cfg_enh,
  .at_fifo_bytes, .iso_fmt);

/* testbench/test_link_enhancement_control.sv */
// self-checking bench for the link tuning register block
// assumes the block answers apb within a few cycles of the setup
`timescale 1ns/1ps
module test_link_enhancement_control;
  import lec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cfg_load, er;
  logic at_retries_zero, at_eop_in_fifo, at_underrun, at_pkt_done, start;
  logic at_send_permit, at_store_fwd, async_pipeline_disable, stamp_apply;
  logic prio_arb_enable, phy_accel_notify, iso_hdr_valid;
  logic [7:0]  paddr, a;
  logic [31:0] pwdata, prdata, rd, w;
  logic [15:0] cfg_enh;
  logic [11:0] at_fifo_bytes;
  logic [5:0]  iso_fmt, f;
  int err_count = 0, samples_checked = 0, cyc = 0, un, n;

  lec_link_tuning i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .cfg_load, .cfg_enh,
    .at_retries_zero, .at_fifo_bytes, .at_eop_in_fifo, .at_underrun,
    .at_pkt_done, .at_send_permit, .at_store_fwd, .async_pipeline_disable,
    .iso_hdr_valid, .iso_fmt, .stamp_apply, .prio_arb_enable,
    .phy_accel_notify);
  lec_fifo_model i_fifo (.pclk, .presetn, .start, .pkt_len(12'h7d0),
    .at_send_permit, .at_fifo_bytes, .at_eop_in_fifo, .at_underrun,
    .at_pkt_done);

  // ------------
  // tasks and expectations
  // ------------
  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic stamp_exp(input logic [1:0] m, logic [5:0] fm);
    return (m[1] && fm == LEC_FMT_MPEG) || (m[0] && fm == LEC_FMT_DV);
  endfunction
  function automatic int un_exp(input logic [1:0] t, input logic rz);
    return (!rz && t != LEC_THR_2K) ? 1 : 0;
  endfunction
  // status after a finished packet: permit up, retry pass over
  function automatic logic [31:0] stat_exp(input logic [1:0] t,
                                           input logic rz);
    return {27'h0, 2'b10, (t == LEC_THR_2K) || rz, t};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, cfg_load, at_retries_zero} = '0;
    {iso_hdr_valid, start, paddr, pwdata, cfg_enh, iso_fmt} = '0;
    void'($urandom(48));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, LEC_CTRL_OFF, 32'h0);
    chk("ctrl reset", LEC_CTRL_RST, rd);
    apb(1'b1, LEC_STAT_OFF, 32'hffff_ffff);
    chk("status write refused", 32'h1, er);
    repeat (24) begin
      w = $urandom;
      a = 8'($urandom);
      apb(1'b1, LEC_CTRL_OFF, w);
      apb(1'b0, LEC_CTRL_OFF, 32'h0);
      chk("ctrl readback", w & 32'h0000_b582, rd);
      chk("ctrl outputs", {w[15], w[7], w[1]}, {async_pipeline_disable,
          prio_arb_enable, phy_accel_notify});
      if (a != LEC_CTRL_OFF && a != LEC_STAT_OFF) begin
        apb(1'b0, a, 32'h0);
        chk("unmapped refused", 32'h1, er);
      end
    end
    cfg_enh  <= 16'hffff;
    cfg_load <= 1'b1;
    @(posedge pclk);
    cfg_load <= 1'b0;
    apb(1'b0, LEC_CTRL_OFF, 32'h0);
    chk("memory load", 32'h0000_b582, rd);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, LEC_CTRL_OFF, {21'h0, m[1], 1'b0, m[0], 8'h00});
      for (int k = 0; k < 3; k++) begin
        f = (k == 0) ? LEC_FMT_DV : (k == 1) ? LEC_FMT_MPEG : 6'($urandom);
        iso_hdr_valid <= 1'b1;
        iso_fmt <= f;
        @(posedge pclk);
        iso_hdr_valid <= 1'b0;
        @(posedge pclk);
        chk("stamp", stamp_exp(m[1:0], f), stamp_apply);
      end
    end
    for (int t = 0; t < 4; t++) begin
      for (int z = 0; z < 2; z++) begin
        at_retries_zero <= z[0];
        apb(1'b1, LEC_CTRL_OFF, {18'h0, t[1:0], 12'h000});
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        un = 0;
        n = 0;
        do begin
          @(posedge pclk);
          if (at_underrun === 1'b1)
            un++;
          n++;
        end while (at_pkt_done !== 1'b1 && n < 600);
        chk("underruns", un_exp(t[1:0], z[0]), un);
        chk("packet done", 32'h1, at_pkt_done);
        apb(1'b0, LEC_STAT_OFF, 32'h0);
        chk("status", stat_exp(t[1:0], z[0]), rd);
      end
    end
    results();
  end
endmodule
